// ### design/uds_regs.vh
// Register offsets, field positions, reset values and timing for the USB status block
`ifndef UDS_REGS_VH
`define UDS_REGS_VH

// Register offsets (word index on the plain register port)
`define UDS_CTRL_ADDR 4'h0
`define UDS_STATUS_ADDR 4'h1
`define UDS_MASK_ADDR 4'h2
`define UDS_EP0_ADDR 4'h3

// Control register fields
`define UDS_CTRL_EP0_IE 0
`define UDS_CTRL_EP1_IE 1
`define UDS_CTRL_WAKE 5
`define UDS_CTRL_CLK_GATE 6

// Status register fields
`define UDS_ST_CONFIG 0
`define UDS_ST_REQUEST 1
`define UDS_ST_FRAME 2
`define UDS_ST_SETTING 3
`define UDS_ST_BUS_RESET 4
`define UDS_ST_WAKE 5
`define UDS_ST_SLEEP 6

// Mask register fields (bit 0 is the write-only halt force)
`define UDS_MK_HALT 0

// Endpoint 0 register fields
`define UDS_EP0_COUNT_LSB 0
`define UDS_EP0_TX_ARMED 4
`define UDS_EP0_TX_DONE 5
`define UDS_EP0_RX_PENDING 6
`define UDS_EP0_RX_DONE 7

// Reset values
`define UDS_RESET_BYTE 8'h00
`define UDS_RESET_NIBBLE 4'h0

// Token reply codes
`define UDS_REPLY_NONE 2'h0
`define UDS_REPLY_DATA 2'h1
`define UDS_REPLY_NAK 2'h2
`define UDS_REPLY_STALL 2'h3

// Timing: 3 ms of 100 MHz cycles, resume one cycle longer
`define UDS_IDLE_CYCLES 20'h493e0
`define UDS_RESUME_CYCLES 20'h493e1
`define UDS_TIMER_W 20

`endif

// ### design/uds_sync2.v
// Two-flop synchroniser for one pin
`timescale 1ns/10ps
module uds_sync2 (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire d_i,
   output reg q_o
);
   reg meta;

   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         meta <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// ### design/uds_timer.v
// Cycle timer that pulses after every LIMIT cycles while run_i stays high
`timescale 1ns/10ps
`include "uds_regs.vh"
module uds_timer #(
   parameter [`UDS_TIMER_W-1:0] LIMIT = 20'h003e8
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire run_i,
   output reg done_o
);
   reg [`UDS_TIMER_W-1:0] count;
   wire at_end;

   assign at_end = (count == LIMIT - {{(`UDS_TIMER_W-1){1'b0}}, 1'b1});

   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         count <= {`UDS_TIMER_W{1'b0}};
         done_o <= 1'b0;
      end else if (!run_i) begin
         count <= {`UDS_TIMER_W{1'b0}};
         done_o <= 1'b0;
      end else if (at_end) begin
         count <= {`UDS_TIMER_W{1'b0}};
         done_o <= 1'b1;
      end else begin
         count <= count + {{(`UDS_TIMER_W-1){1'b0}}, 1'b1};
         done_o <= 1'b0;
      end
   end
endmodule

// ### design/uds_status_ep0.v
// USB device status, event masks and endpoint 0 handshake control
`timescale 1ns/10ps
`include "uds_regs.vh"
module uds_status_ep0 #(
   parameter [`UDS_TIMER_W-1:0] IDLE_CYCLES = `UDS_IDLE_CYCLES,
   parameter [`UDS_TIMER_W-1:0] RESUME_CYCLES = `UDS_RESUME_CYCLES
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire dp_i,
   input wire dm_i,
   output reg dp_o,
   output reg dm_o,
   output reg dp_oe_o,
   output reg dm_oe_o,
   input wire setup_req_i,
   input wire setup_pkt_i,
   input wire sof_i,
   input wire config_set_i,
   input wire config_value_i,
   input wire remote_wake_en_i,
   input wire bus_reset_i,
   input wire reset_redirect_i,
   input wire in_token_i,
   input wire in_ack_i,
   input wire out_token_i,
   input wire out_ok_i,
   input wire [3:0] out_count_i,
   input wire [3:0] ep_done_i,
   output reg reply_valid_o,
   output reg [1:0] reply_code_o,
   output reg [3:0] tx_count_o,
   output reg irq_o,
   output reg cpu_reset_req_o,
   output reg usb_clk_en_o,
   output reg suspended_o
);
   localparam [1:0] ST_ACTIVE = 2'h0;
   localparam [1:0] ST_SUSPEND = 2'h1;
   localparam [1:0] ST_RESUME = 2'h2;

   // Flag update: hardware set wins over a software zero write
   function flag_next;
      input cur;
      input set;
      input clr;
      begin
         flag_next = set | (cur & ~clr);
      end
   endfunction

   // Register select for one access strobe
   function hit;
      input strobe;
      input [3:0] addr;
      input [3:0] target;
      begin
         hit = strobe & (addr == target);
      end
   endfunction

   reg [1:0] state;
   reg [1:0] next_state;
   reg config_num;
   reg request_flag;
   reg frame_start_flag;
   reg setting_change_flag;
   reg bus_reset_flag;
   reg wake_activity_flag;
   reg bus_sleep_flag;
   reg request_irq_mask;
   reg frame_start_irq_mask;
   reg setting_change_irq_mask;
   reg bus_reset_irq_mask;
   reg wake_activity_irq_mask;
   reg bus_sleep_irq_mask;
   reg ep_zero_halt_force;
   reg ep_zero_done_irq_enable;
   reg [3:0] endpoint_done_irq_enable;
   reg module_clock_gate;
   reg [3:0] ep_zero_rx_count;
   reg [3:0] ep_zero_tx_count;
   reg ep_zero_tx_armed;
   reg ep_zero_tx_done;
   reg ep_zero_rx_pending;
   reg ep_zero_rx_done;

   wire dp_s;
   wire dm_s;
   wire line_j;
   wire idle_done;
   wire resume_done;
   wire wr_ctrl;
   wire wr_status;
   wire wr_mask;
   wire wr_ep0;
   wire wake_req;
   wire go_sleep;
   wire activity;
   wire irq_any;

   uds_sync2 u_sync_dp (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .d_i(dp_i),
      .q_o(dp_s)
   );

   uds_sync2 u_sync_dm (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .d_i(dm_i),
      .q_o(dm_s)
   );

   // Full-speed idle is the J state
   assign line_j = dp_s & ~dm_s;

   uds_timer #(.LIMIT(IDLE_CYCLES)) u_idle_timer (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .run_i((state == ST_ACTIVE) & line_j),
      .done_o(idle_done)
   );

   uds_timer #(.LIMIT(RESUME_CYCLES)) u_resume_timer (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .run_i(state == ST_RESUME),
      .done_o(resume_done)
   );

   assign wr_ctrl = hit(wr_i, addr_i, `UDS_CTRL_ADDR);
   assign wr_status = hit(wr_i, addr_i, `UDS_STATUS_ADDR);
   assign wr_mask = hit(wr_i, addr_i, `UDS_MASK_ADDR);
   assign wr_ep0 = hit(wr_i, addr_i, `UDS_EP0_ADDR);

   assign wake_req = wr_ctrl & wdata_i[`UDS_CTRL_WAKE] & remote_wake_en_i;
   assign go_sleep = (state == ST_ACTIVE) & idle_done;
   assign activity = (state == ST_SUSPEND) & ~wake_req & ~line_j;

   // Link power state
   always @* begin
      next_state = state;
      case (state)
         ST_ACTIVE: begin
            if (idle_done) begin
               next_state = ST_SUSPEND;
            end
         end
         ST_SUSPEND: begin
            if (wake_req) begin
               next_state = ST_RESUME;
            end else if (~line_j) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_RESUME: begin
            if (resume_done) begin
               next_state = ST_ACTIVE;
            end
         end
         default: begin
            next_state = ST_ACTIVE;
         end
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state <= ST_ACTIVE;
         dp_o <= 1'b0;
         dm_o <= 1'b0;
         dp_oe_o <= 1'b0;
         dm_oe_o <= 1'b0;
         suspended_o <= 1'b0;
      end else begin
         state <= next_state;
         // K state: D+ low, D- high, driven only during resume
         dp_o <= 1'b0;
         dm_o <= (next_state == ST_RESUME);
         dp_oe_o <= (next_state == ST_RESUME);
         dm_oe_o <= (next_state == ST_RESUME);
         suspended_o <= (next_state == ST_SUSPEND);
      end
   end

   // Control register
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ep_zero_done_irq_enable <= 1'b0;
         endpoint_done_irq_enable <= `UDS_RESET_NIBBLE;
         module_clock_gate <= 1'b0;
         usb_clk_en_o <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ep_zero_done_irq_enable <= wdata_i[`UDS_CTRL_EP0_IE];
            endpoint_done_irq_enable <= wdata_i[`UDS_CTRL_EP1_IE+3:`UDS_CTRL_EP1_IE];
            module_clock_gate <= wdata_i[`UDS_CTRL_CLK_GATE];
         end
         usb_clk_en_o <= wr_ctrl ? wdata_i[`UDS_CTRL_CLK_GATE] : module_clock_gate;
      end
   end

   // Bus status flags
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         config_num <= 1'b0;
         request_flag <= 1'b0;
         frame_start_flag <= 1'b0;
         setting_change_flag <= 1'b0;
         bus_reset_flag <= 1'b0;
         wake_activity_flag <= 1'b0;
         bus_sleep_flag <= 1'b0;
      end else begin
         if (config_set_i) begin
            config_num <= config_value_i;
         end
         request_flag <= flag_next(request_flag, setup_req_i,
            wr_status & ~wdata_i[`UDS_ST_REQUEST]);
         frame_start_flag <= flag_next(frame_start_flag, sof_i,
            wr_status & ~wdata_i[`UDS_ST_FRAME]);
         setting_change_flag <= flag_next(setting_change_flag, config_set_i,
            wr_status & ~wdata_i[`UDS_ST_SETTING]);
         bus_reset_flag <= flag_next(bus_reset_flag, bus_reset_i,
            wr_status & ~wdata_i[`UDS_ST_BUS_RESET]);
         wake_activity_flag <= flag_next(wake_activity_flag, activity,
            wr_status & ~wdata_i[`UDS_ST_WAKE]);
         bus_sleep_flag <= flag_next(bus_sleep_flag, go_sleep,
            wr_status & ~wdata_i[`UDS_ST_SLEEP]);
      end
   end

   // Interrupt masks
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         request_irq_mask <= 1'b0;
         frame_start_irq_mask <= 1'b0;
         setting_change_irq_mask <= 1'b0;
         bus_reset_irq_mask <= 1'b0;
         wake_activity_irq_mask <= 1'b0;
         bus_sleep_irq_mask <= 1'b0;
      end else if (wr_mask) begin
         request_irq_mask <= wdata_i[`UDS_ST_REQUEST];
         frame_start_irq_mask <= wdata_i[`UDS_ST_FRAME];
         setting_change_irq_mask <= wdata_i[`UDS_ST_SETTING];
         bus_reset_irq_mask <= wdata_i[`UDS_ST_BUS_RESET];
         wake_activity_irq_mask <= wdata_i[`UDS_ST_WAKE];
         bus_sleep_irq_mask <= wdata_i[`UDS_ST_SLEEP];
      end
   end

   // Endpoint 0 control and status
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ep_zero_halt_force <= 1'b0;
         ep_zero_rx_count <= `UDS_RESET_NIBBLE;
         ep_zero_tx_count <= `UDS_RESET_NIBBLE;
         ep_zero_tx_armed <= 1'b0;
         ep_zero_tx_done <= 1'b0;
         ep_zero_rx_pending <= 1'b0;
         ep_zero_rx_done <= 1'b0;
      end else begin
         // Halt force: set by a one write, cleared only by SETUP
         if (wr_mask & wdata_i[`UDS_MK_HALT]) begin
            ep_zero_halt_force <= 1'b1;
         end else if (setup_pkt_i) begin
            ep_zero_halt_force <= 1'b0;
         end
         if (wr_ep0) begin
            ep_zero_tx_count <= wdata_i[`UDS_EP0_COUNT_LSB+3:`UDS_EP0_COUNT_LSB];
         end
         if (out_ok_i | setup_pkt_i) begin
            ep_zero_rx_count <= out_count_i;
         end
         // Software write to the armed bit wins over a hardware clear in the same cycle
         if (wr_ep0) begin
            ep_zero_tx_armed <= wdata_i[`UDS_EP0_TX_ARMED];
         end else if (in_ack_i | setup_pkt_i) begin
            ep_zero_tx_armed <= 1'b0;
         end
         ep_zero_tx_done <= flag_next(ep_zero_tx_done, in_ack_i,
            wr_ep0 & ~wdata_i[`UDS_EP0_TX_DONE]);
         ep_zero_rx_pending <= flag_next(ep_zero_rx_pending, out_ok_i,
            wr_ep0 & ~wdata_i[`UDS_EP0_RX_PENDING]);
         ep_zero_rx_done <= flag_next(ep_zero_rx_done, out_ok_i | setup_pkt_i,
            wr_ep0 & ~wdata_i[`UDS_EP0_RX_DONE]);
      end
   end

   // Token replies for endpoint 0
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         reply_valid_o <= 1'b0;
         reply_code_o <= `UDS_REPLY_NONE;
         tx_count_o <= `UDS_RESET_NIBBLE;
      end else begin
         reply_valid_o <= in_token_i | out_token_i;
         tx_count_o <= ep_zero_tx_count;
         if (in_token_i) begin
            if (ep_zero_halt_force) begin
               reply_code_o <= `UDS_REPLY_STALL;
            end else if (ep_zero_tx_done | ~ep_zero_tx_armed) begin
               reply_code_o <= `UDS_REPLY_NAK;
            end else begin
               reply_code_o <= `UDS_REPLY_DATA;
            end
         end else if (out_token_i) begin
            if (ep_zero_halt_force) begin
               reply_code_o <= `UDS_REPLY_STALL;
            end else if (ep_zero_rx_done | ep_zero_rx_pending) begin
               reply_code_o <= `UDS_REPLY_NAK;
            end else begin
               reply_code_o <= `UDS_REPLY_DATA;
            end
         end else begin
            reply_code_o <= `UDS_REPLY_NONE;
         end
      end
   end

   // Interrupt request and internal reset request
   assign irq_any = (request_flag & request_irq_mask)
      | (frame_start_flag & frame_start_irq_mask)
      | (setting_change_flag & setting_change_irq_mask)
      | (wake_activity_flag & wake_activity_irq_mask)
      | (bus_sleep_flag & bus_sleep_irq_mask)
      | (bus_reset_flag & reset_redirect_i & bus_reset_irq_mask)
      | (ep_zero_done_irq_enable & (ep_zero_tx_done | ep_zero_rx_done))
      | (|(endpoint_done_irq_enable & ep_done_i));

   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
         cpu_reset_req_o <= 1'b0;
      end else begin
         irq_o <= irq_any;
         cpu_reset_req_o <= bus_reset_i & ~reset_redirect_i;
      end
   end

   // Register read port, data one cycle after the strobe
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rdata_o <= `UDS_RESET_BYTE;
      end else if (rd_i) begin
         case (addr_i)
            `UDS_CTRL_ADDR: begin
               // Wake bit always reads zero
               rdata_o <= {1'b0, module_clock_gate, 1'b0, endpoint_done_irq_enable,
                  ep_zero_done_irq_enable};
            end
            `UDS_STATUS_ADDR: begin
               rdata_o <= {1'b0, bus_sleep_flag, wake_activity_flag, bus_reset_flag,
                  setting_change_flag, frame_start_flag, request_flag, config_num};
            end
            `UDS_MASK_ADDR: begin
               rdata_o <= {1'b0, bus_sleep_irq_mask, wake_activity_irq_mask,
                  bus_reset_irq_mask, setting_change_irq_mask, frame_start_irq_mask,
                  request_irq_mask, 1'b0};
            end
            `UDS_EP0_ADDR: begin
               rdata_o <= {ep_zero_rx_done, ep_zero_rx_pending, ep_zero_tx_done,
                  ep_zero_tx_armed, ep_zero_rx_count};
            end
            default: begin
               rdata_o <= `UDS_RESET_BYTE;
            end
         endcase
      end else begin
         rdata_o <= `UDS_RESET_BYTE;
      end
   end

endmodule

// ### verification/uds_status_ep0_properties.sv
// Concurrent property checker for the USB status and endpoint 0 block
`timescale 1ns/10ps
`include "uds_regs.vh"
module uds_status_ep0_props #(
   parameter [19:0] RESUME_CYCLES = 20'h00014
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire dp_o,
   input wire dm_o,
   input wire dp_oe_o,
   input wire dm_oe_o,
   input wire remote_wake_en_i,
   input wire bus_reset_i,
   input wire reset_redirect_i,
   input wire in_token_i,
   input wire out_token_i,
   input wire reply_valid_o,
   input wire [1:0] reply_code_o,
   input wire [3:0] tx_count_o,
   input wire cpu_reset_req_o,
   input wire usb_clk_en_o,
   input wire suspended_o
);
   reg [19:0] run_len;
   reg wake_hit;
   // Length of the current drive and a registered copy of a permitted wake write
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         run_len <= 20'h00000;
         wake_hit <= 1'b0;
      end else begin
         run_len <= dp_oe_o ? run_len + 20'h00001 : 20'h00000;
         wake_hit <= wr_i && addr_i == `UDS_CTRL_ADDR && wdata_i[5] && remote_wake_en_i
            && suspended_o;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   wake_reads_zero_a: assert property (
      rd_i && addr_i == `UDS_CTRL_ADDR |=> !rdata_o[5]) else $error("wake bit read back set");
   halt_reads_zero_a: assert property (
      rd_i && addr_i == `UDS_MASK_ADDR |=> !rdata_o[0]) else $error("halt bit read back set");
   token_reply_a: assert property (
      in_token_i || out_token_i |=> reply_valid_o && reply_code_o != `UDS_REPLY_NONE)
      else $error("token without reply");
   no_stray_reply_a: assert property (
      !(in_token_i || out_token_i) |=> !reply_valid_o) else $error("reply without token");
   wake_cause_a: assert property (
      $rose(dp_oe_o) |-> wake_hit || $past(wake_hit)) else $error("resume drive without cause");
   resume_level_a: assert property (
      dp_oe_o |-> dm_oe_o && !dp_o && dm_o) else $error("resume drive not K");
   resume_length_a: assert property (
      $fell(dp_oe_o) |-> run_len >= RESUME_CYCLES) else $error("resume drive too short");
   bus_reset_cpu_a: assert property (
      bus_reset_i && !reset_redirect_i |=> cpu_reset_req_o) else $error("no internal reset");
   redirect_quiet_a: assert property (
      !(bus_reset_i && !reset_redirect_i) |=> !cpu_reset_req_o) else $error("stray cpu reset");
   tx_count_copy_a: assert property (
      wr_i && addr_i == `UDS_EP0_ADDR ##1 !(wr_i && addr_i == `UDS_EP0_ADDR)
      |=> tx_count_o == $past(wdata_i[3:0], 2)) else $error("tx count not loaded");
   clock_gate_a: assert property (
      wr_i && addr_i == `UDS_CTRL_ADDR |=> usb_clk_en_o == $past(wdata_i[6]))
      else $error("clock gate not written");
   cover property (in_token_i ##1 reply_code_o == `UDS_REPLY_STALL);
   cover property ($fell(dp_oe_o));
   cover property ($rose(suspended_o));
endmodule
bind uds_status_ep0 uds_status_ep0_props #(.RESUME_CYCLES(RESUME_CYCLES)) props_inst (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .dp_o(dp_o), .dm_o(dm_o), .dp_oe_o(dp_oe_o),
   .dm_oe_o(dm_oe_o), .remote_wake_en_i(remote_wake_en_i), .bus_reset_i(bus_reset_i),
   .reset_redirect_i(reset_redirect_i), .in_token_i(in_token_i), .out_token_i(out_token_i),
   .reply_valid_o(reply_valid_o), .reply_code_o(reply_code_o), .tx_count_o(tx_count_o),
   .cpu_reset_req_o(cpu_reset_req_o), .usb_clk_en_o(usb_clk_en_o), .suspended_o(suspended_o)
);

// ### verification/uds_host_model.sv
// Host side model: bus line state, tokens and request events
`timescale 1ns/10ps
module uds_host_model (
   input wire ref_clk_i,
   output reg [8:0] ev_o,
   output reg [3:0] count_o,
   output reg cfg_value_o,
   output reg wake_en_o,
   output wire dp_o,
   output wire dm_o
);
   reg idle;
   initial begin
      ev_o = 9'h000;
      count_o = 4'h0;
      cfg_value_o = 1'b0;
      wake_en_o = 1'b0;
      idle = 1'b0;
   end
   // J while idle, K while busy
   assign dp_o = idle;
   assign dm_o = !idle;
   // One-cycle token or event with its byte count
   task pulse(input [3:0] which, input [3:0] cnt);
      begin
         @(posedge ref_clk_i);
         ev_o[which] <= 1'b1;
         count_o <= cnt;
         @(posedge ref_clk_i);
         ev_o <= 9'h000;
      end
   endtask
endmodule

// ### verification/uds_status_ep0_test.sv
// Self-checking bench for the USB status and endpoint 0 block
`timescale 1ns/10ps
`include "uds_regs.vh"
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
   n_errors = n_errors + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uds_status_ep0_test;
   reg ref_clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg [3:0] addr_i = 4'h0;
   reg [7:0] wdata_i = 8'h00;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg [3:0] ep_done_i = 4'h0;
   reg reset_redirect_i = 1'b0;
   wire [7:0] rdata_o;
   wire [1:0] reply_code_o;
   wire [3:0] tx_count_o;
   wire [8:0] h_ev;
   wire [3:0] h_cnt;
   wire dp_o, dm_o, dp_oe_o, dm_oe_o, reply_valid_o, irq_o, cpu_reset_req_o, usb_clk_en_o;
   wire suspended_o, h_cfg, h_wake, h_dp, h_dm;
   wire dp_w = dp_oe_o ? dp_o : h_dp;
   wire dm_w = dm_oe_o ? dm_o : h_dm;
   integer n_errors = 0;
   integer num_checks = 0;
   integer cycles = 0;
   integer i;
   uds_status_ep0 #(.IDLE_CYCLES(20'h00014), .RESUME_CYCLES(20'h00014)) uds_status_ep0_inst (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .dp_i(dp_w), .dm_i(dm_w), .dp_o(dp_o), .dm_o(dm_o),
      .dp_oe_o(dp_oe_o), .dm_oe_o(dm_oe_o), .setup_req_i(h_ev[0]), .setup_pkt_i(h_ev[1]),
      .sof_i(h_ev[2]), .config_set_i(h_ev[3]), .config_value_i(h_cfg),
      .remote_wake_en_i(h_wake), .bus_reset_i(h_ev[4]), .reset_redirect_i(reset_redirect_i),
      .in_token_i(h_ev[5]), .in_ack_i(h_ev[6]), .out_token_i(h_ev[7]), .out_ok_i(h_ev[8]),
      .out_count_i(h_cnt), .ep_done_i(ep_done_i), .reply_valid_o(reply_valid_o),
      .reply_code_o(reply_code_o), .tx_count_o(tx_count_o), .irq_o(irq_o),
      .cpu_reset_req_o(cpu_reset_req_o), .usb_clk_en_o(usb_clk_en_o), .suspended_o(suspended_o)
   );
   uds_host_model host_inst (.ref_clk_i(ref_clk_i), .ev_o(h_ev), .count_o(h_cnt),
      .cfg_value_o(h_cfg), .wake_en_o(h_wake), .dp_o(h_dp), .dm_o(h_dm));
   always #5 ref_clk_i = ~ref_clk_i;
   task wrap_up;
      begin
         if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   always @(posedge ref_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         wrap_up;
      end
   end
   task tick(input integer n);
      begin
         repeat (n) @(posedge ref_clk_i);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge ref_clk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge ref_clk_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge ref_clk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge ref_clk_i);
         rd_i <= 1'b0;
         #1;
         `CHK(rdata_o, e)
      end
   endtask
   task tok(input [3:0] w, input [1:0] code);
      begin
         host_inst.pulse(w, 4'h0);
         #1;
         `CHK(reply_valid_o, 1'b1)
         `CHK(reply_code_o, code)
      end
   endtask
   task wait_sleep;
      for (i = 0; i < 100 && suspended_o !== 1'b1; i = i + 1) tick(1);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      for (i = 0; i < 5; i = i + 1) rd(i[3:0], 8'h00);
      wr(4'h0, 8'h7f);
      rd(4'h0, 8'h5f);
      `CHK(dp_oe_o, 1'b0)
      @(posedge ref_clk_i) host_inst.cfg_value_o <= 1'b1;
      for (i = 0; i < 4; i = i + 1) host_inst.pulse(i == 0 ? 4'h0 : i[3:0] + 4'h1, 4'h0);
      #1 `CHK(cpu_reset_req_o, 1'b1)
      rd(4'h1, 8'h1f);
      wr(4'h1, 8'hff);
      rd(4'h1, 8'h1f);
      wr(4'h1, 8'h00);
      rd(4'h1, 8'h01);
      wr(4'h2, 8'h7e);
      rd(4'h2, 8'h7e);
      @(posedge ref_clk_i) reset_redirect_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         host_inst.pulse(i == 0 ? 4'h0 : i[3:0] + 4'h1, 4'h0);
         #1 `CHK(cpu_reset_req_o, 1'b0)
         tick(1);
         `CHK(irq_o, 1'b1)
         wr(4'h1, 8'h00);
         tick(2);
         `CHK(irq_o, 1'b0)
      end
      @(posedge ref_clk_i) reset_redirect_i <= 1'b0;
      host_inst.pulse(4'h4, 4'h0);
      tick(2);
      `CHK(irq_o, 1'b0)
      wr(4'h1, 8'h00);
      tok(4'h5, `UDS_REPLY_NAK);
      wr(4'h3, 8'h15);
      tick(1);
      `CHK(tx_count_o, 4'h5)
      tok(4'h5, `UDS_REPLY_DATA);
      host_inst.pulse(4'h6, 4'h0);
      rd(4'h3, 8'h20);
      wr(4'h0, 8'h01);
      tick(2);
      `CHK(irq_o, 1'b1)
      tok(4'h5, `UDS_REPLY_NAK);
      wr(4'h3, 8'hf5);
      rd(4'h3, 8'h30);
      tok(4'h5, `UDS_REPLY_NAK);
      wr(4'h3, 8'h10);
      rd(4'h3, 8'h10);
      `CHK(irq_o, 1'b0)
      tok(4'h5, `UDS_REPLY_DATA);
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h00);
      tok(4'h7, `UDS_REPLY_DATA);
      host_inst.pulse(4'h8, 4'h9);
      rd(4'h3, 8'hc9);
      `CHK(irq_o, 1'b1)
      tok(4'h7, `UDS_REPLY_NAK);
      wr(4'h3, 8'h80);
      rd(4'h3, 8'h89);
      tok(4'h7, `UDS_REPLY_NAK);
      wr(4'h3, 8'h40);
      rd(4'h3, 8'h09);
      tok(4'h7, `UDS_REPLY_DATA);
      wr(4'h0, 8'h02);
      @(posedge ref_clk_i) ep_done_i <= 4'h1;
      tick(2);
      `CHK(irq_o, 1'b1)
      @(posedge ref_clk_i) ep_done_i <= 4'h0;
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h00);
      tok(4'h5, `UDS_REPLY_STALL);
      tok(4'h7, `UDS_REPLY_STALL);
      wr(4'h2, 8'h00);
      tok(4'h5, `UDS_REPLY_STALL);
      wr(4'h3, 8'h10);
      host_inst.pulse(4'h1, 4'h8);
      rd(4'h3, 8'h88);
      tok(4'h5, `UDS_REPLY_NAK);
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h40);
      @(posedge ref_clk_i) host_inst.idle <= 1'b1;
      wait_sleep;
      `CHK(i >= 20, 1'b1)
      rd(4'h1, 8'h41);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h60);
      tick(2);
      `CHK(dp_oe_o, 1'b0)
      @(posedge ref_clk_i) host_inst.wake_en_o <= 1'b1;
      wr(4'h0, 8'h60);
      tick(1);
      `CHK({dp_oe_o, dp_o, dm_o}, 3'b101)
      for (i = 0; i < 200 && dp_oe_o === 1'b1; i = i + 1) tick(1);
      `CHK(i >= 19, 1'b1)
      `CHK(suspended_o, 1'b0)
      rd(4'h0, 8'h40);
      wr(4'h1, 8'h00);
      wait_sleep;
      @(posedge ref_clk_i) host_inst.idle <= 1'b0;
      tick(6);
      `CHK(suspended_o, 1'b0)
      rd(4'h1, 8'h61);
      wrap_up;
   end
endmodule
